// ### rtl/pdp_map.svh
`ifndef PDP_MAP_SVH
`define PDP_MAP_SVH

// ==========================================================
// register indices (byte address is four times the index)
`define PDP_IDX_CLK_CTRL 16'hFFD0
`define PDP_IDX_DUTY_UP 16'hFFD1
`define PDP_IDX_DUTY_LO 16'hFFD2
`define PDP_IDX_PORT_MODE 16'hFFD3
`define PDP_IDX_STATUS 16'hFFD4

// ==========================================================
// reset values and read-back patterns
`define PDP_RST_CLK_CTRL 8'hFE
`define PDP_RST_DUTY_UP 8'hC0
`define PDP_RST_DUTY_LO 8'h00
`define PDP_RST_DUTY 14'h0000
`define PDP_READ_ONES 8'hFF
`define PDP_UP_FILL 2'h3

// ==========================================================
// field positions
`define PDP_CLK_SEL_BIT 0
`define PDP_PIN_EN_BIT 0
`define PDP_ST_SEL_BIT 14
`define PDP_ST_PEND_BIT 15
`define PDP_ST_OUT_BIT 16
`define PDP_ST_PIN_BIT 17

// ==========================================================
// timing: system clock 100 MHz
`define PDP_CLK_PERIOD_NS 10
`define PDP_PERIOD_SEL0_CLKS 16384
`define PDP_PERIOD_SEL1_CLKS 32768
`define PDP_SUB_PULSES 64
`define PDP_HIGH_OFFSET 64

`endif

// ### rtl/pdp_pkg.sv
package pdp_pkg;

    // ==========================================================
    // bus carriers
    localparam int unsigned PDP_ADR_W = 18;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [PDP_ADR_W-1:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } pdp_wb_req_t;

    typedef struct packed {
        logic ack;
        logic err;
        logic [31:0] dat;
    } pdp_wb_rsp_t;

    // ==========================================================
    // register selection
    typedef enum {
        PDP_SEL_NONE,
        PDP_SEL_CLK,
        PDP_SEL_UP,
        PDP_SEL_LO,
        PDP_SEL_PORT,
        PDP_SEL_STATUS
    } pdp_reg_sel_t;

endpackage

// ### rtl/pdp_pwm.sv
// Function
// - select 0: period 16384 clocks, step one clock
// - select 1: period 32768 clocks, step two clocks
// - control resets to FE, bits 7..1 fixed one
// - clock select write-only, always reads one
// - duty is 14 bits, upper 6 plus lower 8
// - total high time is min(duty+64, 16384) steps
// - period split into 64 sub-pulses
// - upper write latches duty, applied at period start
// - duty registers write-only, read all ones
// - duty registers reset to C000, duty zero
// - drive waveform only while pin assigned
`timescale 1ns/10ps
`include "pdp_map.svh"

module pdp_pwm #(
    parameter int unsigned DUTY_W = 14,
    parameter int unsigned PULSE_W = 6
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire pdp_pkg::pdp_wb_req_t wb_req_i,
    output pdp_pkg::pdp_wb_rsp_t wb_rsp_o,
    output logic pwm_o
);
    import pdp_pkg::*;

    localparam int unsigned SUB_W = DUTY_W - PULSE_W;
    localparam int unsigned PERIOD0 = `PDP_PERIOD_SEL0_CLKS;
    localparam int unsigned PERIOD1 = `PDP_PERIOD_SEL1_CLKS;

    // ==========================================================
    // elaboration checks
    initial begin
        if (DUTY_W != 14) begin
            $error("duty width must be 14");
        end
        if ((1 << PULSE_W) != `PDP_SUB_PULSES) begin
            $error("sub-pulse count must be 64");
        end
        if (PERIOD1 != 2 * PERIOD0) begin
            $error("period ratio must be two");
        end
    end

    // ==========================================================
    // functions
    function automatic logic adr_hit(
        input logic [PDP_ADR_W-1:0] adr,
        input logic [15:0] idx
    );
        logic [PDP_ADR_W-1:0] base;
        base = {idx, 2'b00};
        return adr == base;
    endfunction

    function automatic logic [PULSE_W-1:0] bit_rev(
        input logic [PULSE_W-1:0] v
    );
        logic [PULSE_W-1:0] r;
        r = '0;
        for (int i = 0; i < PULSE_W; i++) begin
            r[i] = v[PULSE_W-1-i];
        end
        return r;
    endfunction

    // ==========================================================
    // state
    logic clk_sel_r;
    logic pin_en_r;
    logic [7:0] duty_lo_r;
    logic [DUTY_W-1:0] staged_r;
    logic pend_r;
    logic [DUTY_W-1:0] gen_duty_r;
    logic pre_r;
    logic [DUTY_W-1:0] phase_r;
    pdp_wb_rsp_t rsp_r;
    logic out_r;

    logic req;
    logic wr_lane0;
    pdp_reg_sel_t reg_sel;
    logic tick;
    logic wrap;
    logic apply;
    logic wr_clk;
    logic wr_up;
    logic wr_lo;
    logic wr_port;
    logic [PULSE_W-1:0] pulse_idx;
    logic [SUB_W-1:0] sub_pos;
    logic [SUB_W+1:0] high_len;
    logic extra;
    logic out_nxt;
    logic [31:0] rd_nxt;

    assign wb_rsp_o = rsp_r;
    assign pwm_o = out_r;

    // ==========================================================
    // address decode
    assign req = wb_req_i.cyc & wb_req_i.stb & ~rsp_r.ack & ~rsp_r.err;
    assign wr_lane0 = req & wb_req_i.we & wb_req_i.sel[0];

    always_comb begin
        if (adr_hit(wb_req_i.adr, `PDP_IDX_CLK_CTRL)) begin
            reg_sel = PDP_SEL_CLK;
        end else if (adr_hit(wb_req_i.adr, `PDP_IDX_DUTY_UP)) begin
            reg_sel = PDP_SEL_UP;
        end else if (adr_hit(wb_req_i.adr, `PDP_IDX_DUTY_LO)) begin
            reg_sel = PDP_SEL_LO;
        end else if (adr_hit(wb_req_i.adr, `PDP_IDX_PORT_MODE)) begin
            reg_sel = PDP_SEL_PORT;
        end else if (adr_hit(wb_req_i.adr, `PDP_IDX_STATUS)) begin
            reg_sel = PDP_SEL_STATUS;
        end else begin
            reg_sel = PDP_SEL_NONE;
        end
    end

    assign wr_clk = wr_lane0 & (reg_sel == PDP_SEL_CLK);
    assign wr_up = wr_lane0 & (reg_sel == PDP_SEL_UP);
    assign wr_lo = wr_lane0 & (reg_sel == PDP_SEL_LO);
    assign wr_port = wr_lane0 & (reg_sel == PDP_SEL_PORT);

    // ==========================================================
    // read data
    always_comb begin
        rd_nxt = 32'h0000_0000;
        case (reg_sel)
            PDP_SEL_CLK: begin
                rd_nxt[7:0] = `PDP_READ_ONES;
            end
            PDP_SEL_UP: begin
                rd_nxt[7:0] = `PDP_READ_ONES;
            end
            PDP_SEL_LO: begin
                rd_nxt[7:0] = `PDP_READ_ONES;
            end
            PDP_SEL_PORT: begin
                rd_nxt[`PDP_PIN_EN_BIT] = pin_en_r;
            end
            PDP_SEL_STATUS: begin
                rd_nxt[DUTY_W-1:0] = gen_duty_r;
                rd_nxt[`PDP_ST_SEL_BIT] = clk_sel_r;
                rd_nxt[`PDP_ST_PEND_BIT] = pend_r;
                rd_nxt[`PDP_ST_OUT_BIT] = out_r;
                rd_nxt[`PDP_ST_PIN_BIT] = pin_en_r;
            end
            default: begin
                rd_nxt = 32'h0000_0000;
            end
        endcase
    end

    // ==========================================================
    // bus answer: one cycle after the request, dropped next cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rsp_r <= '0;
        end else begin
            rsp_r.ack <= req & (reg_sel != PDP_SEL_NONE);
            rsp_r.err <= req & (reg_sel == PDP_SEL_NONE);
            if (req & ~wb_req_i.we) begin
                rsp_r.dat <= rd_nxt;
            end else begin
                rsp_r.dat <= 32'h0000_0000;
            end
        end
    end

    // ==========================================================
    // clock control and pin routing
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            clk_sel_r <= 1'(`PDP_RST_CLK_CTRL >> `PDP_CLK_SEL_BIT);
        end else if (wr_clk) begin
            clk_sel_r <= wb_req_i.dat[`PDP_CLK_SEL_BIT];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_en_r <= 1'b0;
        end else if (wr_port) begin
            pin_en_r <= wb_req_i.dat[`PDP_PIN_EN_BIT];
        end
    end

    // ==========================================================
    // duty registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            duty_lo_r <= `PDP_RST_DUTY_LO;
        end else if (wr_lo) begin
            duty_lo_r <= wb_req_i.dat[7:0];
        end
    end

    // upper write takes the held lower byte with it
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            staged_r <= {6'(`PDP_RST_DUTY_UP & 8'h3F), `PDP_RST_DUTY_LO};
        end else if (wr_up) begin
            staged_r <= {wb_req_i.dat[5:0], duty_lo_r};
        end
    end

    // a write in the apply cycle keeps the pending flag set
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pend_r <= 1'b0;
        end else if (wr_up) begin
            pend_r <= 1'b1;
        end else if (apply) begin
            pend_r <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            gen_duty_r <= `PDP_RST_DUTY;
        end else if (apply) begin
            gen_duty_r <= staged_r;
        end
    end

    // ==========================================================
    // time base: one step per input clock at select 0, per two clocks at select 1
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pre_r <= 1'b0;
        end else if (clk_sel_r) begin
            pre_r <= ~pre_r;
        end else begin
            pre_r <= 1'b0;
        end
    end

    assign tick = ~clk_sel_r | pre_r;
    assign wrap = tick & (&phase_r);
    assign apply = wrap & pend_r;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            phase_r <= '0;
        end else if (tick) begin
            phase_r <= phase_r + 1'b1;
        end
    end

    // ==========================================================
    // pulse division
    assign pulse_idx = phase_r[DUTY_W-1:SUB_W];
    assign sub_pos = phase_r[SUB_W-1:0];
    assign extra = bit_rev(pulse_idx) < gen_duty_r[PULSE_W-1:0];

    // each sub-pulse: base share plus one, plus one spread step where extra is set
    assign high_len = {2'b00, gen_duty_r[DUTY_W-1:PULSE_W]}
        + {{(SUB_W+1){1'b0}}, 1'b1}
        + {{(SUB_W+1){1'b0}}, extra};

    assign out_nxt = pin_en_r & ({2'b00, sub_pos} < high_len);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            out_r <= 1'b0;
        end else begin
            out_r <= out_nxt;
        end
    end

endmodule

// ### tb/pdp_pwm_checker.sv
`timescale 1ns/10ps
module pdp_pwm_checker (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire pdp_pkg::pdp_wb_req_t wb_req_i,
    input wire pdp_pkg::pdp_wb_rsp_t wb_rsp_o,
    input wire logic pwm_o
);
    import pdp_pkg::*;
    logic tk;
    logic um;
    logic ro;
    assign tk = wb_req_i.cyc && wb_req_i.stb && !wb_rsp_o.ack && !wb_rsp_o.err;
    assign um = (wb_req_i.adr[1:0] != 2'b00)
        || !(wb_req_i.adr[17:2] inside {[16'hFFD0:16'hFFD4]});
    assign ro = !wb_req_i.we && (wb_req_i.adr[17:2] inside {[16'hFFD0:16'hFFD2]});
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // ==========================================
    // bus answers
    property p_map; tk && !um |=> wb_rsp_o.ack && !wb_rsp_o.err; endproperty
    a_map: assert property (p_map) else $error("mapped request not acked");
    property p_unm; tk && um |=> wb_rsp_o.err && !wb_rsp_o.ack && wb_rsp_o.dat == 32'h0; endproperty
    a_unm: assert property (p_unm) else $error("unmapped request not refused");
    property p_ones; wb_rsp_o.ack && ro |-> wb_rsp_o.dat == 32'h0000_00FF; endproperty
    a_ones: assert property (p_ones) else $error("register read not all ones");
    property p_ackp; wb_rsp_o.ack |=> !wb_rsp_o.ack; endproperty
    a_ackp: assert property (p_ackp) else $error("ack longer than a cycle");
    property p_errp; wb_rsp_o.err |=> !wb_rsp_o.err; endproperty
    a_errp: assert property (p_errp) else $error("err longer than a cycle");
    property p_spur; !tk |=> !wb_rsp_o.ack && !wb_rsp_o.err; endproperty
    a_spur: assert property (p_spur) else $error("answer without request");
    property p_idle; !wb_rsp_o.ack |-> wb_rsp_o.dat == 32'h0; endproperty
    a_idle: assert property (p_idle) else $error("read data outside ack");
    property p_rst; $fell(rst_i) |-> !pwm_o && !wb_rsp_o.ack; endproperty
    a_rst: assert property (p_rst) else $error("outputs active after reset");
    c_wr: cover property (tk && wb_req_i.we);
    c_err: cover property (wb_rsp_o.err);
    c_pwm: cover property ($rose(pwm_o));
endmodule
bind pdp_pwm pdp_pwm_checker i_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req_i),
    .wb_rsp_o(wb_rsp_o), .pwm_o(pwm_o));

// ### tb/pdp_lpf.sv
`timescale 1ns/10ps
module pdp_lpf (
    input wire logic clk_i,
    input wire logic pwm_i,
    input wire logic clr_i,
    output logic [31:0] acc_o
);
    // filter as an integrator: high clocks since clear
    always_ff @(posedge clk_i) begin
        if (clr_i) begin
            acc_o <= 32'h0;
        end else begin
            acc_o <= acc_o + {31'h0, pwm_i};
        end
    end
endmodule

// ### tb/tb_top.sv
`timescale 1ns/10ps
module tb_top;
    import pdp_pkg::*;
    logic clk_i;
    logic rst_i;
    pdp_wb_req_t rq;
    pdp_wb_rsp_t rs;
    logic pwm;
    logic clr;
    logic [31:0] acc;
    logic [31:0] s;
    logic [31:0] q;
    logic e;
    int err_count;
    int n_checks;
    pdp_pwm i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(rq), .wb_rsp_o(rs), .pwm_o(pwm));
    pdp_lpf i_lpf (.clk_i(clk_i), .pwm_i(pwm), .clr_i(clr), .acc_o(acc));
    // ==========================================
    // helpers
    function automatic logic [31:0] xs();
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        s = s ^ (s << 5);
        return s;
    endfunction
    function automatic int hi_model(int duty, int sel);
        return (duty + 64) * (sel + 1);
    endfunction
    task automatic chk(input string what, input logic [31:0] x, input logic [31:0] g);
        n_checks++;
        if (g !== x) begin
            err_count++;
            $display("[ERR] %s expected %0h seen %0h", what, x, g);
        end
    endtask
    task automatic chk_rng(input string what, input int lo, input int hi, input int g);
        n_checks++;
        if (g < lo || g > hi) begin
            err_count++;
            $display("[ERR] %s expected %0d..%0d seen %0d", what, lo, hi, g);
        end
    endtask
    task automatic wb(input logic we, input logic [15:0] idx, input logic [31:0] d);
        int n = 0;
        rq <= '{1'b1, 1'b1, we, {idx, 2'b00}, 4'hF, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (!(rs.ack || rs.err) && n < 50);
        q = rs.dat;
        e = rs.err;
        if (n >= 50) begin
            err_count++;
            $display("[ERR] bus_answer expected 1 seen 0");
        end
        rq <= '0;
        @(posedge clk_i);
    endtask
    task automatic rd(input logic [15:0] idx, input logic [31:0] x);
        wb(1'b0, idx, 32'h0);
        chk("read", x, q);
    endtask
    task automatic meas(input int cyc, input int x);
        clr <= 1'b1;
        @(posedge clk_i);
        clr <= 1'b0;
        repeat (cyc + 1) @(posedge clk_i);
        chk("high_time", x, acc);
    endtask
    // eight consecutive sub-pulse windows at select 1, 512 clocks each
    task automatic spread(input int b);
        logic [31:0] a0;
        a0 = acc;
        for (int i = 0; i < 8; i++) begin
            repeat (512) @(posedge clk_i);
            chk_rng("sub_pulse", 2 * (b + 1), 2 * (b + 2), acc - a0);
            a0 = acc;
        end
    endtask
    task automatic settle();
        int n = 0;
        do begin
            wb(1'b0, 16'hFFD4, 32'h0);
            n++;
        end while (q[15] !== 1'b0 && n < 20000);
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // ==========================================
    // stimulus
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    initial begin
        repeat (95000) @(posedge clk_i);
        err_count++;
        $display("[ERR] watchdog expected done seen timeout");
        summarize();
    end
    initial begin
        int d;
        rst_i = 1'b1;
        rq = '0;
        clr = 1'b0;
        s = 32'd88;
        err_count = 0;
        n_checks = 0;
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rd(16'hFFD0, 32'hFF);
        rd(16'hFFD1, 32'hFF);
        rd(16'hFFD2, 32'hFF);
        rd(16'hFFD4, 32'h0);
        wb(1'b0, 16'hFF00, 32'h0);
        chk("err", 32'h1, {31'h0, e});
        meas(512, 0);
        $display("test reset done");
        wb(1'b1, 16'hFFD3, 32'h1);
        wb(1'b1, 16'hFFD0, xs() & 32'hFE);
        rd(16'hFFD0, 32'hFF);
        meas(16384, hi_model(0, 0));
        $display("test duty zero done");
        d = int'(xs() % 32'd16320);
        wb(1'b1, 16'hFFD0, xs() | 32'h1);
        wb(1'b1, 16'hFFD2, d & 32'hFF);
        wb(1'b1, 16'hFFD1, d >> 8);
        settle();
        chk("status", {16'h0, 1'b0, 1'b1, d[13:0]}, {16'h0, q[15:0]});
        meas(32768, hi_model(d, 1));
        spread(d >> 6);
        $display("test random duty done");
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rd(16'hFFD4, 32'h0);
        rd(16'hFFD1, 32'hFF);
        $display("test second reset done");
        summarize();
    end
endmodule
